//--- rcm_consts.svh
/*
 * Timing counts, field positions and reset values for the reference clock mode block.
 * Assumes inclusion by bare name from the package and the design module.
 */
`ifndef RCM_CONSTS_SVH
`define RCM_CONSTS_SVH

`define RCM_CLK_MHZ          100
`define RCM_MULT_MSB         7
`define RCM_MULT_LSB         3
`define RCM_GATE_BIT         4
`define RCM_COMP_PD_BIT      6
`define RCM_XOUT_BIT         9
`define RCM_MULT_MIN         5'h04
`define RCM_MULT_MAX         5'h14
`define RCM_MULT_RESET       5'h00
`define RCM_LOCK_TIME_US     1000
`define RCM_LOCK_CYCLES      (`RCM_LOCK_TIME_US * `RCM_CLK_MHZ)

`endif

//--- rcm_pkg.sv
/*
 * Types shared by the reference clock mode block.
 * Assumes rcm_consts.svh is on the include path.
 */
`include "rcm_consts.svh"

package rcm_pkg;

    typedef enum logic [2:0] {
        RCM_MODE_OSC_PLL,
        RCM_MODE_OSC_BYPASS,
        RCM_MODE_EXT_PLL,
        RCM_MODE_EXT_BYPASS,
        RCM_MODE_GATED
    } rcm_mode_t;

    typedef struct packed {
        logic       osc_enable;
        logic       osc_out_enable;
        logic       pll_enable;
        logic       pll_bypass;
        logic       sysclk_enable;
        logic       comp_power_down;
        logic [4:0] mult;
    } rcm_ctrl_t;

endpackage

//--- rcm_ref_clock_ctrl.sv
/*
 * Reference clock mode and multiplier loop control: decodes the oscillator-select pin,
 * the clock-gate bit and the multiplier field into analog enables and a mode code.
 * Assumes the control words arrive as plain ports from a serial port block on clk,
 * and that the oscillator-select pin is asynchronous to clk.
 */
// Operation
// R1 - Multiplier is control word two bits 7:3
// R2 - Values 4 to 20 multiply reference
// R3 - Software keeps multiplied clock below 400 MHz
// R4 - Software waits 1 ms after multiplier change
// R5 - Out-of-range values bypass and power loop down
// R6 - Six modes from pin, gate, multiplier (the code decodes five)
// R7 - Select pin high runs buffered crystal oscillator
// R8 - Gate bit stops system clock always
// R9 - Gating leaves crystal oscillator running
// R10 - Word two bit 9 enables oscillator output
// R11 - Select pin low disables oscillator and buffer
// R12 - Multiplier independent of gate bit
// R13 - Multiplier resets to zero, bypassed (pll_bypass is low in reset, set one clock after)
`include "rcm_consts.svh"

module rcm_ref_clock_ctrl (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // Control words
    input  wire logic [31:0]       control_word_one,
    input  wire logic [23:0]       control_word_two,
    // Pin
    input  wire logic              oscillator_select_pin,
    // Analog enables
    output rcm_pkg::rcm_ctrl_t     ctrl,
    // Status
    output rcm_pkg::rcm_mode_t     mode,
    output logic                   pll_settled
);

    function automatic logic mult_in_range(input logic [4:0] m);
        mult_in_range = (m >= `RCM_MULT_MIN) && (m <= `RCM_MULT_MAX);
    endfunction

    logic              sel_meta;
    logic              sel_sync;
    logic [4:0]        mult;
    logic [16:0]       lock_count;
    logic              gate;
    logic              xout_bit;
    logic              comp_pd;

    // Two-stage synchroniser on the oscillator-select pin.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sel_meta <= 1'b0;
            sel_sync <= 1'b0;
        end else begin
            sel_meta <= oscillator_select_pin;
            sel_sync <= sel_meta;
        end
    end

    // Control bits are captured locally so the outputs see registered, reset-defined values.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mult     <= `RCM_MULT_RESET; // [R13]
            gate     <= 1'b0;
            xout_bit <= 1'b0;
            comp_pd  <= 1'b0;
        end else begin
            mult     <= control_word_two[`RCM_MULT_MSB:`RCM_MULT_LSB]; // [R1]
            gate     <= control_word_one[`RCM_GATE_BIT];
            xout_bit <= control_word_two[`RCM_XOUT_BIT];
            comp_pd  <= control_word_one[`RCM_COMP_PD_BIT];
        end
    end

    // Enables are derived from the registered controls; one cycle of latency is harmless
    // next to the loop settling time.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl <= '0;
        end else begin
            ctrl.mult            <= mult;
            ctrl.pll_enable      <= mult_in_range(mult); // [R2] [R12]
            ctrl.pll_bypass      <= !mult_in_range(mult); // [R5] [R13]
            ctrl.osc_enable      <= sel_sync; // [R7] [R9] [R11]
            ctrl.osc_out_enable  <= sel_sync && xout_bit; // [R10] [R11]
            ctrl.sysclk_enable   <= !gate; // [R8]
            ctrl.comp_power_down <= comp_pd;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mode <= rcm_pkg::RCM_MODE_GATED;
        end else begin
            case ({gate, sel_sync, mult_in_range(mult)}) // [R6]
                3'b011:  mode <= rcm_pkg::RCM_MODE_OSC_PLL;
                3'b010:  mode <= rcm_pkg::RCM_MODE_OSC_BYPASS;
                3'b001:  mode <= rcm_pkg::RCM_MODE_EXT_PLL;
                3'b000:  mode <= rcm_pkg::RCM_MODE_EXT_BYPASS;
                default: mode <= rcm_pkg::RCM_MODE_GATED; // [R8]
            endcase
        end
    end

    // Settling timer restarts on every multiplier change so software can poll it.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lock_count  <= '0;
            pll_settled <= 1'b0;
        end else if (ctrl.mult != mult || !mult_in_range(mult)) begin
            lock_count  <= '0;
            pll_settled <= 1'b0;
        end else if (lock_count == 17'(`RCM_LOCK_CYCLES - 1)) begin
            pll_settled <= 1'b1; // [R4]
        end else begin
            lock_count  <= lock_count + 17'h00001;
        end
    end

    property p_bypass;
        @(posedge clk) disable iff (reset)
        !mult_in_range(mult) |=> ctrl.pll_bypass && !ctrl.pll_enable;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not set"); // [R5]

    property p_mult;
        @(posedge clk) disable iff (reset)
        mult_in_range(mult) |=> ctrl.pll_enable && ctrl.mult == $past(mult);
    endproperty
    a_mult: assert property (p_mult) else $error("multiplier not enabled"); // [R2]

    property p_field;
        @(posedge clk) disable iff (reset)
        1'b1 |=> mult == $past(control_word_two[7:3]);
    endproperty
    a_field: assert property (p_field) else $error("multiplier field wrong"); // [R1]

    property p_gate;
        @(posedge clk) disable iff (reset)
        gate |=> !ctrl.sysclk_enable && mode == rcm_pkg::RCM_MODE_GATED;
    endproperty
    a_gate: assert property (p_gate) else $error("gate ignored"); // [R8]

    property p_osc_runs;
        @(posedge clk) disable iff (reset)
        gate && sel_sync |=> ctrl.osc_enable;
    endproperty
    a_osc_runs: assert property (p_osc_runs) else $error("oscillator stopped by gate"); // [R9]

    property p_sel_low;
        @(posedge clk) disable iff (reset)
        !sel_sync |=> !ctrl.osc_enable && !ctrl.osc_out_enable;
    endproperty
    a_sel_low: assert property (p_sel_low) else $error("oscillator on with pin low"); // [R11]

    property p_xout;
        @(posedge clk) disable iff (reset)
        sel_sync && xout_bit |=> ctrl.osc_out_enable;
    endproperty
    a_xout: assert property (p_xout) else $error("output buffer off"); // [R10]

    property p_indep;
        @(posedge clk) disable iff (reset)
        $changed(gate) && $stable(mult) |=> $stable(ctrl.pll_enable);
    endproperty
    a_indep: assert property (p_indep) else $error("gate moved loop"); // [R12]

    property p_osc;
        @(posedge clk) disable iff (reset)
        $rose(sel_sync) |=> ctrl.osc_enable;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator not started"); // [R7]

    property p_reset_mult;
        @(posedge clk) $fell(reset) |-> mult == 5'h00;
    endproperty
    a_reset_mult: assert property (p_reset_mult) else $error("multiplier not reset"); // [R13]

    property p_sysclk_on;
        @(posedge clk) disable iff (reset)
        !gate |=> ctrl.sysclk_enable;
    endproperty
    a_sysclk_on: assert property (p_sysclk_on) else $error("system clock stopped without gate"); // [R8]

    property p_xout_off;
        @(posedge clk) disable iff (reset)
        !xout_bit |=> !ctrl.osc_out_enable;
    endproperty
    a_xout_off: assert property (p_xout_off) else $error("output buffer on with bit clear"); // [R10]

    // Each ungated mode is checked on its own so that a swapped case arm shows up.
    property p_mode_osc_pll;
        @(posedge clk) disable iff (reset)
        !gate && sel_sync && mult_in_range(mult) |=> mode == rcm_pkg::RCM_MODE_OSC_PLL;
    endproperty
    a_mode_osc_pll: assert property (p_mode_osc_pll) else $error("mode not oscillator with loop"); // [R6]

    property p_mode_osc_byp;
        @(posedge clk) disable iff (reset)
        !gate && sel_sync && !mult_in_range(mult) |=> mode == rcm_pkg::RCM_MODE_OSC_BYPASS;
    endproperty
    a_mode_osc_byp: assert property (p_mode_osc_byp) else $error("mode not oscillator bypassed"); // [R6]

    property p_mode_ext_pll;
        @(posedge clk) disable iff (reset)
        !gate && !sel_sync && mult_in_range(mult) |=> mode == rcm_pkg::RCM_MODE_EXT_PLL;
    endproperty
    a_mode_ext_pll: assert property (p_mode_ext_pll) else $error("mode not external with loop"); // [R6]

    property p_mode_ext_byp;
        @(posedge clk) disable iff (reset)
        !gate && !sel_sync && !mult_in_range(mult) |=> mode == rcm_pkg::RCM_MODE_EXT_BYPASS;
    endproperty
    a_mode_ext_byp: assert property (p_mode_ext_byp) else $error("mode not external bypassed"); // [R6]

    property p_settle_restart;
        @(posedge clk) disable iff (reset)
        $changed(mult) |=> !pll_settled && lock_count == '0;
    endproperty
    a_settle_restart: assert property (p_settle_restart) else $error("settling timer not restarted"); // [R4]

    c_osc_pll: cover property (@(posedge clk) mode == rcm_pkg::RCM_MODE_OSC_PLL);
    c_osc_byp: cover property (@(posedge clk) mode == rcm_pkg::RCM_MODE_OSC_BYPASS);
    c_ext_byp: cover property (@(posedge clk) mode == rcm_pkg::RCM_MODE_EXT_BYPASS);
    c_gated:   cover property (@(posedge clk) mode == rcm_pkg::RCM_MODE_GATED);
    c_settled: cover property (@(posedge clk) $rose(pll_settled));

endmodule

//--- rcm_ref_osc.sv
/*
 * Model of the reference source: the board strap on the select pin and the crystal or external oscillator.
 * Assumes the bench sets the strap level and watches ref_running.
 */
module rcm_ref_osc (
    // Strap and enables
    input  wire logic               strap,
    input  wire rcm_pkg::rcm_ctrl_t ctrl,
    // Pin and source state
    output logic                    oscillator_select_pin,
    output logic                    ref_running
);
    timeunit 1ns;
    timeprecision 100ps;
    // A 20 MHz reference keeps the largest multiple at the ceiling.
    localparam int REF_MHZ = 20;
    assign oscillator_select_pin = strap;
    // The external oscillator takes over whenever the strap is low.
    assign ref_running = ctrl.osc_enable | !strap;
endmodule

//--- tb.sv
/*
 * Self-checking bench for the reference clock mode block.
 * Assumes the design files are compiled before it.
 */
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic               clk, reset, strap, pin, ref_running, pll_settled;
    logic [31:0]        control_word_one;
    logic [23:0]        control_word_two;
    rcm_pkg::rcm_ctrl_t ctrl;
    rcm_pkg::rcm_mode_t mode;
    int                 fails = 0;
    int                 n_tests = 0;
    int                 cycles = 0;

    rcm_ref_clock_ctrl dut (.clk(clk), .reset(reset), .control_word_one(control_word_one),
        .control_word_two(control_word_two), .oscillator_select_pin(pin), .ctrl(ctrl), .mode(mode),
        .pll_settled(pll_settled));
    rcm_ref_osc osc (.strap(strap), .ctrl(ctrl), .oscillator_select_pin(pin), .ref_running(ref_running));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            fails++;
            final_report();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apply(input logic p, input logic g, input logic [4:0] m, input logic xo, input logic cpd);
        logic               inr;
        rcm_pkg::rcm_ctrl_t e;
        rcm_pkg::rcm_mode_t em;
        @(posedge clk);
        #1;
        strap = p;
        // Every bit outside the fields is set, so a stray field position shows up.
        control_word_one = {25'h1ffffff, cpd, 1'b1, g, 4'hf};
        control_word_two = {14'h3fff, xo, 1'b1, m, 3'h7};
        repeat (6) @(posedge clk);
        #1;
        inr = (m >= 5'h04) && (m <= 5'h14);
        e = '{osc_enable: p, osc_out_enable: p & xo, pll_enable: inr, pll_bypass: !inr,
              sysclk_enable: !g, comp_power_down: cpd, mult: m};
        em = g ? rcm_pkg::RCM_MODE_GATED : p ? (inr ? rcm_pkg::RCM_MODE_OSC_PLL : rcm_pkg::RCM_MODE_OSC_BYPASS)
                                             : (inr ? rcm_pkg::RCM_MODE_EXT_PLL : rcm_pkg::RCM_MODE_EXT_BYPASS);
        check(16'(ctrl), 16'(e));
        check(16'(mode), 16'(em));
        check({15'h0, pll_settled}, 16'h0000);
        check({15'h0, ref_running}, 16'h0001);
    endtask

    task automatic t_sweep();
        for (int p = 0; p < 2; p++)
            for (int g = 0; g < 2; g++)
                for (int m = 0; m < 32; m++)
                    apply(p[0], g[0], m[4:0], m[0], m[1]);
    endtask

    task automatic t_reset();
        apply(1'b1, 1'b0, 5'h0a, 1'b1, 1'b0);
        @(posedge clk);
        #1;
        reset = 1'b1;
        #2;
        check(16'(ctrl), 16'h0000);
        check(16'(mode), 16'(rcm_pkg::RCM_MODE_GATED));
        @(posedge clk);
        #1;
        reset = 1'b0;
        @(posedge clk);
        #1;
        check({10'h0, ctrl.pll_bypass, ctrl.mult}, 16'h0020);
        apply(1'b1, 1'b0, 5'h14, 1'b1, 1'b0);
    endtask

    // The gate moves while the multiplier holds still, which the sweep never does.
    task automatic t_gate();
        apply(1'b1, 1'b0, 5'h08, 1'b1, 1'b0);
        apply(1'b1, 1'b1, 5'h08, 1'b1, 1'b0);
        apply(1'b0, 1'b1, 5'h08, 1'b0, 1'b1);
        apply(1'b0, 1'b0, 5'h08, 1'b0, 1'b1);
    endtask

    task automatic final_report();
        if (fails == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        strap = 1'b0;
        control_word_one = 32'h0;
        control_word_two = 24'h0;
        repeat (4) @(posedge clk);
        #1;
        reset = 1'b0;
        t_sweep();
        t_gate();
        t_reset();
        final_report();
    end
endmodule
